/* cfs_pkg.sv */
package cfs_pkg;

  // ******************************************************
  // Register map
  // ******************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_LEVEL2_BIT = 1;
  localparam int CTRL_QAM256_BIT = 2;
  localparam int CTRL_CW_LSB = 4;
  localparam int STAT_RSVD_BIT = 0;
  localparam int STAT_TRAIL_BIT = 1;
  localparam int STAT_CW_LSB = 4;
  localparam int STAT_FRAMES_LSB = 16;

  // ******************************************************
  // Frame layout
  // ******************************************************
  localparam int SYM_W = 7;
  localparam int NUM_BRANCH = 128;
  localparam int RS_BLOCK_SYMS = 128;
  localparam int BLOCKS_64 = 60;
  localparam int BLOCKS_256 = 88;
  localparam logic [13:0] LAST_DATA_64 = 14'(BLOCKS_64 * RS_BLOCK_SYMS - 1);
  localparam logic [13:0] LAST_DATA_256 = 14'(BLOCKS_256 * RS_BLOCK_SYMS - 1);
  localparam logic [2:0] LAST_TRAIL_SLOT = 3'h5;
  localparam logic [2:0] FULL_SLOT_BITS = 3'h7;
  localparam logic [2:0] PART_SLOT_BITS_256 = 3'h5;
  localparam logic [27:0] SYNC_64 = {7'h75, 7'h2C, 7'h0D, 7'h6C};
  localparam logic [31:0] SYNC_256 = 32'h71E84DD4;
  localparam logic [6:0] RAND_PRELOAD = 7'h7F;
  localparam logic [6:0] FIELD_POLY_LOW = 7'h09;

  // ******************************************************
  // Reset values
  // ******************************************************
  localparam logic [3:0] CW_RESET = 4'h1;
  localparam logic [6:0] BR_M1_RESET = 7'h7F;
  localparam logic [4:0] INCR_RESET = 5'h01;

  // ******************************************************
  // Types
  // ******************************************************
  typedef struct packed {
    logic [3:0] cw;
    logic qam256;
    logic level2;
    logic enable;
  } cfs_ctrl_s;

  typedef struct packed {
    logic ok;
    logic [6:0] br_m1;
    logic [4:0] incr;
  } cfs_cfg_s;

  typedef enum logic [1:0] {
    ST_TRAIL = 2'b01,
    ST_DATA = 2'b10
  } cfs_state_e;

endpackage : cfs_pkg

/* cfs_framer_top.sv */
// Operation
// (R1) Interleave after coder, before randomizer
// (R2) Commutator resets at frame start, advances per symbol
// (R3) 128 branches of 7-bit symbol storage
// (R4) Branch k delays k times increment
// (R5) Receiver applies complementary branch delays
// (R6) Legacy mode fixed 128 by 1
// (R7) Odd codes decode branches/increment; some reserved
// (R8) Even codes: 128 branches, increment 1-4; even codes 8 to 14 fall to the reserved default here
// (R9) Control word sent in every trailer
// (R10) 64-QAM: 60 blocks then 42-bit trailer
// (R11) 64-QAM trailer starts with sync pattern
// (R12) 64-QAM: control bits then ten zeros
// (R13) Encoder inserts trailer; receiver searches it
// (R14) 256-QAM: 88 blocks then 40-bit trailer
// (R15) 256-QAM: sync, control word, four zeros
// (R16) Blocks and symbols align to frame end
// (R17) No transport or trellis synchronisation here
// (R18) Randomizer XORs sequence onto data symbols
// (R19) Randomizer held in trailer, runs after
// (R20) Initialisation loads all ones
// (R21) Symbol LFSR, x^3 + x + alpha^3
// (R22) Field defined by X^7 + X^3 + 1
// (R23) Three stages, output last, alpha^3 feedback
// (R24) Trailer fields sent MSB first
// (R25) Reserved code keeps config, raises flag
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module cfs_framer_top #(
  parameter int MEM_DEPTH = 32512,
  parameter int IDX_W = 15
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Symbols from the block coder
  input wire logic [6:0] IN_SYM,
  input wire logic IN_VALID,
  output logic IN_READY,
  // Symbols to the trellis modulator
  output logic [6:0] OUT_SYM,
  output logic [2:0] OUT_BITS,
  output logic OUT_VALID,
  output logic OUT_TRAIL
);

  // ******************************************************
  // Functions
  // ******************************************************
  function automatic logic [6:0] mul_alpha(input logic [6:0] a);
    mul_alpha = {a[5:0], 1'b0} ^ (a[6] ? cfs_pkg::FIELD_POLY_LOW : 7'h00); // R22
  endfunction : mul_alpha

  function automatic cfs_pkg::cfs_cfg_s decode_cw(input logic level2, input logic [3:0] cw);
    decode_cw = '{ok: 1'b1, br_m1: 7'h7F, incr: 5'h01};
    if (level2)
    begin
      case (cw)
        4'h1: decode_cw = '{ok: 1'b1, br_m1: 7'h7F, incr: 5'h01}; // R7
        4'h3: decode_cw = '{ok: 1'b1, br_m1: 7'h3F, incr: 5'h02}; // R7
        4'h5: decode_cw = '{ok: 1'b1, br_m1: 7'h1F, incr: 5'h04}; // R7
        4'h7: decode_cw = '{ok: 1'b1, br_m1: 7'h0F, incr: 5'h08}; // R7
        4'h9: decode_cw = '{ok: 1'b1, br_m1: 7'h07, incr: 5'h10}; // R7
        4'h0: decode_cw = '{ok: 1'b1, br_m1: 7'h7F, incr: 5'h01}; // R8
        4'h2: decode_cw = '{ok: 1'b1, br_m1: 7'h7F, incr: 5'h02}; // R8
        4'h4: decode_cw = '{ok: 1'b1, br_m1: 7'h7F, incr: 5'h03}; // R8
        4'h6: decode_cw = '{ok: 1'b1, br_m1: 7'h7F, incr: 5'h04}; // R8
        default: decode_cw = '{ok: 1'b0, br_m1: 7'h7F, incr: 5'h01}; // R7
      endcase
    end
  endfunction : decode_cw

  // ******************************************************
  // Registers and state
  // ******************************************************
  cfs_pkg::cfs_ctrl_s ctrl, next_ctrl;
  logic rsvd_flag, next_rsvd_flag;
  logic [15:0] frames, next_frames;
  logic [31:0] prdata, next_prdata;
  logic pready, next_pready;
  logic pslverr, next_pslverr;

  cfs_pkg::cfs_state_e state, next_state;
  logic [13:0] cnt, next_cnt;
  logic [2:0] slot, next_slot;
  logic [6:0] br, next_br;
  logic act_qam, next_act_qam;
  logic [3:0] act_cw, next_act_cw;
  cfs_pkg::cfs_cfg_s act_cfg, next_act_cfg;
  logic [6:0] rnd [3];
  logic [6:0] next_rnd [3];
  logic in_ready, next_in_ready;
  logic [6:0] out_sym, next_out_sym;
  logic [2:0] out_bits, next_out_bits;
  logic out_valid, next_out_valid;
  logic out_trail, next_out_trail;

  logic [6:0] mem [MEM_DEPTH];
  logic [8:0] ptr [cfs_pkg::NUM_BRANCH];
  logic filled [cfs_pkg::NUM_BRANCH];
  logic mem_we, ptr_we, ptr_clr;
  logic [8:0] ptr_val;
  logic [IDX_W-1:0] idx;
  logic [15:0] tri_n;
  logic [8:0] br_len;

  // ******************************************************
  // APB slave
  // ******************************************************
  logic acc, wr_now, hit_ctrl, hit_stat, rsvd_evt;

  always_comb
  begin
    acc = PSEL && PENABLE;
    hit_ctrl = PADDR == cfs_pkg::ADDR_CTRL;
    hit_stat = PADDR == cfs_pkg::ADDR_STATUS;
    wr_now = acc && pready && PWRITE;
    next_pready = acc && !pready;
    next_pslverr = acc && !pready && !hit_ctrl && !hit_stat;
    next_prdata = 32'h0000_0000;
    if (acc && !pready && !PWRITE && hit_ctrl)
    begin
      next_prdata[cfs_pkg::CTRL_ENABLE_BIT] = ctrl.enable;
      next_prdata[cfs_pkg::CTRL_LEVEL2_BIT] = ctrl.level2;
      next_prdata[cfs_pkg::CTRL_QAM256_BIT] = ctrl.qam256;
      next_prdata[cfs_pkg::CTRL_CW_LSB +: 4] = ctrl.cw;
    end
    else if (acc && !pready && !PWRITE && hit_stat)
    begin
      next_prdata[cfs_pkg::STAT_RSVD_BIT] = rsvd_flag;
      next_prdata[cfs_pkg::STAT_TRAIL_BIT] = state == cfs_pkg::ST_TRAIL;
      next_prdata[cfs_pkg::STAT_CW_LSB +: 4] = act_cw;
      next_prdata[cfs_pkg::STAT_FRAMES_LSB +: 16] = frames;
    end
    next_ctrl = ctrl;
    if (wr_now && hit_ctrl)
    begin
      next_ctrl.enable = PWDATA[cfs_pkg::CTRL_ENABLE_BIT];
      next_ctrl.level2 = PWDATA[cfs_pkg::CTRL_LEVEL2_BIT];
      next_ctrl.qam256 = PWDATA[cfs_pkg::CTRL_QAM256_BIT];
      next_ctrl.cw = PWDATA[cfs_pkg::CTRL_CW_LSB +: 4];
    end
    // Sticky flag: a new event wins over a write-one clear
    next_rsvd_flag = rsvd_flag;
    if (wr_now && hit_stat && PWDATA[cfs_pkg::STAT_RSVD_BIT])
    begin
      next_rsvd_flag = 1'b0;
    end
    if (rsvd_evt)
    begin
      next_rsvd_flag = 1'b1; // R25
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ctrl <= '{cw: cfs_pkg::CW_RESET, qam256: 1'b0, level2: 1'b0, enable: 1'b0};
      rsvd_flag <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      ctrl <= next_ctrl;
      rsvd_flag <= next_rsvd_flag;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ******************************************************
  // Framer, interleaver and randomizer
  // ******************************************************
  cfs_pkg::cfs_cfg_s eff_cfg, dec;
  logic eff_qam;
  logic [3:0] eff_cw;
  logic [41:0] trail;
  logic [6:0] il_sym;
  logic take;

  always_comb
  begin
    // New settings are adopted at the first trailer slot only
    dec = decode_cw(ctrl.level2, ctrl.cw); // R6
    eff_cfg = act_cfg;
    eff_qam = act_qam;
    eff_cw = act_cw;
    rsvd_evt = 1'b0;
    ptr_clr = 1'b0;
    if (state == cfs_pkg::ST_TRAIL && ctrl.enable && slot == 3'h0)
    begin
      eff_qam = ctrl.qam256;
      if (dec.ok)
      begin
        eff_cfg = dec;
        eff_cw = ctrl.cw;
        ptr_clr = dec != act_cfg;
      end
      else
      begin
        rsvd_evt = 1'b1; // R25
      end
    end
    if (eff_qam)
    begin
      trail = {cfs_pkg::SYNC_256, eff_cw, 4'h0, 2'b00}; // R9 R15 R24
    end
    else
    begin
      trail = {cfs_pkg::SYNC_64, eff_cw, 10'h000}; // R9 R11 R12 R24
    end
    tri_n = 16'((32'(br) * 32'(br - 7'h01)) >> 1);
    idx = IDX_W'(32'(tri_n) * 32'(act_cfg.incr) + 32'(ptr[br]));
    br_len = 9'(32'(br) * 32'(act_cfg.incr)); // R4 R5
    il_sym = (br == 7'h00) ? IN_SYM : (filled[br] ? mem[idx] : 7'h00); // R3 R4
    take = state == cfs_pkg::ST_DATA && in_ready && IN_VALID;

    next_state = state;
    next_cnt = cnt;
    next_slot = slot;
    next_br = br;
    next_frames = frames;
    next_act_qam = eff_qam;
    next_act_cw = eff_cw;
    next_act_cfg = eff_cfg;
    next_rnd = rnd;
    next_out_sym = out_sym;
    next_out_bits = cfs_pkg::FULL_SLOT_BITS;
    next_out_valid = 1'b0;
    next_out_trail = 1'b0;
    mem_we = 1'b0;
    ptr_we = 1'b0;
    ptr_val = 9'h000;
    case (state)
      cfs_pkg::ST_TRAIL:
      begin
        next_rnd = '{cfs_pkg::RAND_PRELOAD, cfs_pkg::RAND_PRELOAD, // R19 R20
          cfs_pkg::RAND_PRELOAD};
        if (ctrl.enable)
        begin
          next_out_sym = trail[41 - 7 * slot -: 7]; // R13 R24
          next_out_valid = 1'b1;
          next_out_trail = 1'b1; // R19
          if (eff_qam && slot == cfs_pkg::LAST_TRAIL_SLOT)
          begin
            next_out_bits = cfs_pkg::PART_SLOT_BITS_256; // R14
          end
          next_slot = slot + 3'h1;
          if (slot == cfs_pkg::LAST_TRAIL_SLOT)
          begin
            next_state = cfs_pkg::ST_DATA; // R10 R14
            next_slot = 3'h0;
            next_cnt = 14'h0000;
            next_br = 7'h00; // R2
            next_frames = frames + 16'h0001;
          end
        end
      end
      cfs_pkg::ST_DATA:
      begin
        if (take)
        begin
          // Interleave first, then scramble the interleaved symbol
          next_out_sym = il_sym ^ rnd[2]; // R1 R18 R23
          next_out_valid = 1'b1;
          next_rnd[0] = rnd[1] ^ mul_alpha(mul_alpha(mul_alpha(rnd[2]))); // R21 R23
          next_rnd[1] = rnd[0];
          next_rnd[2] = rnd[1];
          mem_we = br != 7'h00;
          ptr_we = br != 7'h00;
          ptr_val = (ptr[br] + 9'h001 == br_len) ? 9'h000 : ptr[br] + 9'h001;
          next_br = (br == act_cfg.br_m1) ? 7'h00 : br + 7'h01; // R2
          next_cnt = cnt + 14'h0001;
          // Data length is a whole number of blocks, so the trailer
          // closes the frame on a symbol and block boundary
          if (cnt == (act_qam ? cfs_pkg::LAST_DATA_256 : cfs_pkg::LAST_DATA_64)) // R16
          begin
            next_state = cfs_pkg::ST_TRAIL;
          end
        end
      end
      default:
      begin
        next_state = cfs_pkg::ST_TRAIL;
      end
    endcase
    // Stream is taken blindly: no transport or trellis alignment
    next_in_ready = next_state == cfs_pkg::ST_DATA && ctrl.enable; // R17
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state <= cfs_pkg::ST_TRAIL;
      cnt <= 14'h0000;
      slot <= 3'h0;
      br <= 7'h00;
      frames <= 16'h0000;
      act_qam <= 1'b0;
      act_cw <= cfs_pkg::CW_RESET;
      act_cfg <= '{ok: 1'b1, br_m1: cfs_pkg::BR_M1_RESET, incr: cfs_pkg::INCR_RESET};
      rnd <= '{cfs_pkg::RAND_PRELOAD, cfs_pkg::RAND_PRELOAD, cfs_pkg::RAND_PRELOAD};
      in_ready <= 1'b0;
      out_sym <= 7'h00;
      out_bits <= cfs_pkg::FULL_SLOT_BITS;
      out_valid <= 1'b0;
      out_trail <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      slot <= next_slot;
      br <= next_br;
      frames <= next_frames;
      act_qam <= next_act_qam;
      act_cw <= next_act_cw;
      act_cfg <= next_act_cfg;
      rnd <= next_rnd;
      in_ready <= next_in_ready;
      out_sym <= next_out_sym;
      out_bits <= next_out_bits;
      out_valid <= next_out_valid;
      out_trail <= next_out_trail;
    end
  end

  // Branch delay lines share one store; each has a circular pointer
  // Cells read as zero until their branch has wrapped once
  generate
    for (genvar k = 0; k < cfs_pkg::NUM_BRANCH; k++)
    begin : g_ptr
      always_ff @(posedge CLK_SYS or negedge RESET_N)
      begin
        if (!RESET_N)
        begin
          ptr[k] <= 9'h000;
          filled[k] <= 1'b0;
        end
        else if (ptr_clr)
        begin
          ptr[k] <= 9'h000;
          filled[k] <= 1'b0;
        end
        else if (ptr_we && br == 7'(k))
        begin
          ptr[k] <= ptr_val; // R4
          filled[k] <= filled[k] || ptr_val == 9'h000;
        end
      end
    end
  endgenerate

  always_ff @(posedge CLK_SYS)
  begin
    if (mem_we)
    begin
      mem[idx] <= IN_SYM; // R3
    end
  end

  assign PRDATA = prdata;
  assign PREADY = pready;
  assign PSLVERR = pslverr;
  assign IN_READY = in_ready;
  assign OUT_SYM = out_sym;
  assign OUT_BITS = out_bits;
  assign OUT_VALID = out_valid;
  assign OUT_TRAIL = out_trail;

endmodule : cfs_framer_top

`default_nettype wire

/* cfs_framer_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module cfs_framer_chk (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  // Register bus
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Symbol stream
  input wire logic IN_VALID,
  input wire logic IN_READY,
  input wire logic [6:0] OUT_SYM,
  input wire logic [2:0] OUT_BITS,
  input wire logic OUT_VALID,
  input wire logic OUT_TRAIL
);
  // ********************
  // Properties
  // ********************
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  sequence s_take;
    IN_VALID && IN_READY;
  endsequence
  sequence s_trailer;
    OUT_TRAIL [*6] ##1 !OUT_TRAIL;
  endsequence
  a_apb_wait: assert property ((PSEL && !PENABLE) |-> ##2 PREADY)
    else $error("slave answer not after one wait state");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready held longer than one cycle");
  a_err_clean: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
    else $error("error response without ready or with data");
  a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data outside a response");
  a_take_answer: assert property (s_take |=> OUT_VALID && !OUT_TRAIL)
    else $error("accepted symbol not answered next cycle");
  a_data_cause: assert property ((OUT_VALID && !OUT_TRAIL) |->
    $past(IN_VALID) && $past(IN_READY))
    else $error("data symbol without an accepted input");
  a_data_bits: assert property ((OUT_VALID && !OUT_TRAIL) |-> OUT_BITS == 3'h7)
    else $error("data symbol not seven bits");
  a_part_slot: assert property (OUT_BITS != 3'h7 |->
    OUT_TRAIL && OUT_BITS == 3'h5 && OUT_SYM[1:0] == 2'h0)
    else $error("short slot outside trailer or badly aligned");
  a_trail_run: assert property ($rose(OUT_TRAIL) |-> s_trailer)
    else $error("trailer not six consecutive slots");
endmodule : cfs_framer_chk

bind cfs_framer_top cfs_framer_chk cfs_framer_chk_i (.CLK_SYS, .RESET_N, .PSEL, .PENABLE,
  .PRDATA, .PREADY, .PSLVERR, .IN_VALID, .IN_READY, .OUT_SYM, .OUT_BITS, .OUT_VALID,
  .OUT_TRAIL);
`default_nettype wire

/* cfs_sym_source.sv */
`timescale 1ns/1ps
`default_nettype none
module cfs_sym_source (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Symbol handshake
  input wire logic in_ready,
  output logic [6:0] in_sym,
  output logic in_valid
);
  // ********************
  // Block coder stand-in
  // ********************
  logic [13:0] cnt;

  // Symbol held until taken; one idle cycle after every fourth, line inverted then
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt <= 14'h0000;
      in_valid <= 1'h0;
      in_sym <= 7'h00;
    end
    else if (in_valid && in_ready)
    begin
      cnt <= cnt + 14'h0001;
      in_valid <= cnt[1:0] != 2'h3;
      in_sym <= (cnt[1:0] != 2'h3) ? 7'(cnt + 14'h0001) ^ 7'h2A : ~in_sym;
    end
    else if (!in_valid)
    begin
      in_valid <= 1'h1;
      in_sym <= 7'(cnt) ^ 7'h2A;
    end
  end
endmodule : cfs_sym_source
`default_nettype wire

/* cfs_framer_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module cfs_framer_top_tb;
  // ********************
  // Bench
  // ********************
  logic clk_sys, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [6:0] in_sym, out_sym;
  logic [2:0] out_bits;
  logic in_valid, in_ready, out_valid, out_trail;
  logic [9:0] trail_q[$];
  logic [6:0] data_q[$];
  int err_count, n_checks;

  cfs_framer_top cfs_framer_top_i (.CLK_SYS(clk_sys), .RESET_N(reset_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .IN_SYM(in_sym), .IN_VALID(in_valid),
    .IN_READY(in_ready), .OUT_SYM(out_sym), .OUT_BITS(out_bits), .OUT_VALID(out_valid),
    .OUT_TRAIL(out_trail));
  cfs_sym_source cfs_sym_source_i (.clk_sys(clk_sys), .reset_n(reset_n),
    .in_ready(in_ready), .in_sym(in_sym), .in_valid(in_valid));

  initial
  begin
    clk_sys = 1'h0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Trailer slots, and the first data symbols of the first frame
  always @(posedge clk_sys)
  begin
    if (out_valid && out_trail)
      trail_q.push_back({out_bits, out_sym});
    else if (out_valid && trail_q.size() == 6 && data_q.size() < 300)
      data_q.push_back(out_sym);
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk_sys);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    @(posedge clk_sys);
    while (!pready)
      @(posedge clk_sys);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic wait_for(input int nt, input int nd);
    while (trail_q.size() < nt || data_q.size() < nd)
      @(posedge clk_sys);
  endtask : wait_for

  function automatic logic [9:0] slot(input logic [41:0] v, input int i, input logic [2:0] b);
    return {b, v[41 - 7 * i -: 7]};
  endfunction : slot

  task automatic t_regs;
    logic [31:0] q;
    logic e;
    apb(1'h0, cfs_pkg::ADDR_CTRL, 32'h0, q, e);
    chk("ctrl reset", q, 32'h0000_0010);
    apb(1'h1, 8'h40, 32'hFFFF_FFFF, q, e);
    chk("unmapped err", 32'(e), 32'h1);
    chk("unmapped data", q, 32'h0);
    apb(1'h0, cfs_pkg::ADDR_CTRL, 32'h0, q, e);
    chk("ctrl kept", q, 32'h0000_0010);
  endtask : t_regs

  task automatic t_frame256;
    logic [6:0] r[$];
    logic [6:0] a;
    logic [31:0] q;
    logic e;
    int m;
    apb(1'h1, cfs_pkg::ADDR_CTRL, 32'h0000_0097, q, e);
    wait_for(6, 300);
    for (int i = 0; i < 6; i++)
      chk("trailer 256", trail_q[i],
        slot({cfs_pkg::SYNC_256, 4'h9, 6'h0}, i, i == 5 ? 3'h5 : 3'h7));
    r = '{7'h7F, 7'h7F, 7'h7F};
    for (int n = 0; n < 300; n++)
    begin
      a = r[n];
      repeat (3) a = {a[5:0], 1'h0} ^ (a[6] ? cfs_pkg::FIELD_POLY_LOW : 7'h00);
      r.push_back(r[n + 1] ^ a);
      m = n - (n % 8) * 128;
      chk("data", data_q[n], r[n] ^ (m < 0 ? 7'h00 : 7'(m) ^ 7'h2A));
    end
  endtask : t_frame256

  task automatic t_reserved;
    logic [31:0] q;
    logic e;
    apb(1'h1, cfs_pkg::ADDR_CTRL, 32'h0000_00B7, q, e);
    wait_for(12, 0);
    chk("kept word", trail_q[10], slot({cfs_pkg::SYNC_256, 4'h9, 6'h0}, 4, 3'h7));
    apb(1'h0, cfs_pkg::ADDR_STATUS, 32'h0, q, e);
    chk("flag and word", {q[31:16], q[7:4], q[1:0]}, {16'h0002, 4'h9, 2'h1});
    apb(1'h1, cfs_pkg::ADDR_STATUS, 32'h0000_0001, q, e);
    apb(1'h0, cfs_pkg::ADDR_STATUS, 32'h0, q, e);
    chk("flag cleared", q[0], 1'h0);
    apb(1'h1, cfs_pkg::ADDR_CTRL, 32'h0000_0031, q, e);
  endtask : t_reserved

  task automatic t_frame64;
    wait_for(18, 0);
    for (int i = 0; i < 4; i++)
      chk("sync 64", trail_q[12 + i], slot({cfs_pkg::SYNC_64, 14'h0}, i, 3'h7));
    chk("ctrl slot", trail_q[16], 10'h398);
    chk("zero slot", trail_q[17], 10'h380);
  endtask : t_frame64

  task automatic close_out;
    if (err_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, reset_n} = '0;
    err_count = 0;
    n_checks = 0;
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'h1;
    t_regs;
    t_frame256;
    t_reserved;
    t_frame64;
    close_out;
  end

  initial
  begin
    repeat (60000) @(posedge clk_sys);
    err_count++;
    close_out;
  end
endmodule : cfs_framer_top_tb
`default_nettype wire
